// >>> logic/arpc_pkg.sv
// Constants, types and helper functions for the amplifier remote packet control block
package arpc_pkg;
  localparam int unsigned CLK_HZ = 250_000_000;
  localparam int unsigned BAUD_RATE = 9600;
  localparam int unsigned CNT_W = 16;
  localparam logic [7:0] ADDR_LOW = 8'h10;
  localparam logic [7:0] ADDR_HIGH = 8'h13;
  localparam logic [7:0] CMD_BASE = 8'h00;
  localparam logic [7:0] CMD_ENABLE = 8'h01;
  localparam logic [7:0] CMD_DISABLE = 8'h02;
  localparam logic [7:0] CMD_EXT = 8'h03;
  localparam logic [7:0] CMD_TEMP = 8'h04;
  localparam logic [8:0] POS_SRC = 9'h000;
  localparam logic [8:0] POS_DST = 9'h001;
  localparam logic [8:0] POS_CMD = 9'h002;
  localparam logic [8:0] POS_LEN = 9'h003;
  localparam logic [8:0] POS_SUM = 9'h004;
  localparam logic [7:0] LEN_NONE = 8'h00;
  localparam logic [7:0] LEN_BASE = 8'h01;
  localparam logic [7:0] LEN_EXT = 8'h02;
  localparam logic [7:0] LEN_TEMP = 8'h01;
  localparam int unsigned RESP_MAX = 7;
  localparam logic [2:0] RESP_HDR = 3'h5;
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam logic [3:0] REG_COUNT = 4'h8;
  localparam int unsigned CTRL_PARITY_EN = 0;
  localparam int unsigned CTRL_PARITY_ODD = 1;
  localparam int unsigned CTRL_CLR_SHUTDOWN = 2;
  localparam logic [1:0] CTRL_RESET = 2'h0;
  localparam logic AMP_EN_RESET = 1'b0;

  typedef enum logic [2:0] {UART_IDLE, UART_START, UART_DATA, UART_PARITY, UART_STOP} arpc_uart_e;

  typedef struct packed {
    logic unit_present_input;
    logic function_ok;
    logic supply_fault;
    logic overpower_alarm;
    logic reflected_power_alarm;
    logic high_temp;
    logic over_temp;
    logic partial_supply_fail;
    logic fan_fail;
    logic fan_on;
    logic loop_fault;
  } arpc_alarm_s;

  function automatic logic [7:0] arpc_add(input logic [7:0] a, input logic [7:0] b);
    arpc_add = a + b;
  endfunction : arpc_add

  function automatic logic arpc_parity(input logic [7:0] d, input logic odd);
    arpc_parity = (^d) ^ odd;
  endfunction : arpc_parity
endpackage : arpc_pkg

// >>> logic/arpc_top.sv
// Remote packet control front end: UART, packet parser, command executor, Avalon-MM slave
// Behaviour
// [RULE1] Characters are 9600 baud, 8N1; parity optional by register, off by default.
// [RULE2] Select high=1/low=0 picks bus 1; high=0/low=1 picks bus 2.
// [RULE3] Only packets addressed 10h to 13h inclusive are acted on.
// [RULE4] Byte 0 source, byte 1 destination, byte 2 command or echo code.
// [RULE5] Byte 3 counts payload bytes after the checksum; it marks the packet end.
// [RULE6] Byte 4 is the additive checksum over header bytes and payload.
// [RULE7] Payload sits at bytes 5 to 4 plus count, only for nonzero count.
// [RULE8] Command 00h, no payload: report base status, amplifier state unchanged.
// [RULE9] Command 01h, no payload: enable amplifier, then report base status.
// [RULE10] Command 02h, no payload: disable amplifier, then report base status.
// [RULE11] Command 03h, no payload: report extended status.
// [RULE12] Command 04h, no payload: report heat sink temperature.
// [RULE13] Unit-present input open means unit missing; grounded means installed.
// [RULE14] Function-fail input high is normal, low is failure.
// [RULE15] Supply fault shuts the amplifier down and is held as a shutdown.
// [RULE16] Overpower alarm never latches; operation resumes when it clears.
// [RULE17] Reflected-power alarm never latches; operation resumes when it clears.
// [RULE18] Correction path fault raises loop-fail; enable/disable line stays undriven.
// [RULE19] Response echo byte repeats the received command code.
// [RULE20] Base status has length 01h and one bit-mapped payload byte.
// [RULE21] Checksum is the 8-bit truncated sum; bad packets are silently dropped.
// [RULE22] Response source is our address, destination is the requester.
// [RULE23] Unknown commands or wrong length counts get no response.
`timescale 1ns/1ns
`default_nettype none
module arpc_top
  import arpc_pkg::*;
#(
  parameter int unsigned BIT_CYCLES = CLK_HZ / BAUD_RATE
)(
  input wire logic clk,
  input wire logic reset,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic bus_select_high,
  input wire logic bus_select_low,
  input wire logic rx_bus1,
  input wire logic rx_bus2,
  output logic tx_bus1,
  output logic tx_bus2,
  output logic tx_enable_bus1,
  output logic tx_enable_bus2,
  input wire arpc_alarm_s alarms,
  input wire logic [7:0] heat_sink_temp,
  output logic amp_enable,
  output logic loop_fail_alarm
);
  localparam logic [CNT_W-1:0] BIT_CNT = CNT_W'(BIT_CYCLES - 1);
  localparam logic [CNT_W-1:0] HALF_CNT = CNT_W'(BIT_CYCLES / 2);

  logic sel1;
  logic sel2;
  logic rx_line;
  logic ack_q;
  logic [1:0] ctrl_q;
  logic supply_shutdown_q;
  logic amp_en_q;
  logic amp_drive_q;
  logic [7:0] cnt_ok_q;
  logic [7:0] cnt_drop_q;
  arpc_uart_e rx_st_q;
  logic [CNT_W-1:0] rx_cnt_q;
  logic [2:0] rx_bit_q;
  logic [7:0] rx_shift_q;
  logic rx_par_q;
  logic rx_valid_q;
  logic rx_err_q;
  logic [8:0] idx_q;
  logic [7:0] src_q;
  logic [7:0] dst_q;
  logic [7:0] cmd_q;
  logic [7:0] len_q;
  logic [7:0] csum_q;
  logic [7:0] sum_q;
  logic pkt_done_q;
  logic last_byte;
  logic [7:0] sum_next;
  logic addr_ok;
  logic sum_ok;
  logic cmd_ok;
  logic accept;
  logic en_next;
  logic [7:0] base_status;
  logic [7:0] ext_status;
  logic [7:0] resp_d [0:RESP_MAX-1];
  logic [2:0] resp_total_d;
  logic [7:0] resp_q [0:RESP_MAX-1];
  logic [2:0] tx_total_q;
  logic [2:0] tx_idx_q;
  arpc_uart_e tx_st_q;
  logic [CNT_W-1:0] tx_cnt_q;
  logic [2:0] tx_bit_q;
  logic [7:0] tx_shift_q;
  logic tx_line_q;
  logic tx_busy;
  logic unit_missing;
  logic function_fail;

  // Bus pair selection; any other select pattern leaves both pairs silent
  assign sel1 = bus_select_high & ~bus_select_low; // RULE2
  assign sel2 = ~bus_select_high & bus_select_low; // RULE2
  assign rx_line = sel1 ? rx_bus1 : (sel2 ? rx_bus2 : 1'b1); // RULE2

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      tx_bus1 <= 1'b1;
      tx_bus2 <= 1'b1;
      tx_enable_bus1 <= 1'b0;
      tx_enable_bus2 <= 1'b0;
    end
    else
    begin
      tx_bus1 <= sel1 ? tx_line_q : 1'b1; // RULE2
      tx_bus2 <= sel2 ? tx_line_q : 1'b1; // RULE2
      tx_enable_bus1 <= sel1 & tx_busy; // RULE2
      tx_enable_bus2 <= sel2 & tx_busy; // RULE2
    end
  end

  // Alarm conditioning
  assign unit_missing = alarms.unit_present_input; // RULE13
  assign function_fail = ~alarms.function_ok; // RULE14

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      supply_shutdown_q <= 1'b0;
    else if (alarms.supply_fault)
      supply_shutdown_q <= 1'b1; // RULE15
    else if (avs_write && ack_q && avs_address == REG_CTRL && avs_byteenable[0]
             && avs_writedata[CTRL_CLR_SHUTDOWN])
      supply_shutdown_q <= 1'b0;
  end

  // Overpower and reflected power only gate the drive while present
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      amp_drive_q <= 1'b0;
      loop_fail_alarm <= 1'b0;
    end
    else
    begin
      amp_drive_q <= amp_en_q & ~supply_shutdown_q & ~alarms.overpower_alarm // RULE16
                     & ~alarms.reflected_power_alarm; // RULE17
      loop_fail_alarm <= alarms.loop_fault; // RULE18
    end
  end
  assign amp_enable = amp_drive_q;

  // UART receiver, sampling mid-bit
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      rx_st_q <= UART_IDLE;
      rx_cnt_q <= '0;
      rx_bit_q <= '0;
      rx_shift_q <= '0;
      rx_par_q <= 1'b0;
      rx_valid_q <= 1'b0;
      rx_err_q <= 1'b0;
    end
    else
    begin
      rx_valid_q <= 1'b0;
      rx_err_q <= 1'b0;
      if (rx_st_q != UART_IDLE && rx_cnt_q != '0)
        rx_cnt_q <= rx_cnt_q - 1'b1;
      else
      begin
        case (rx_st_q)
          UART_IDLE:
            if (!rx_line)
            begin
              rx_cnt_q <= HALF_CNT;
              rx_st_q <= UART_START;
            end
          UART_START:
            if (!rx_line)
            begin
              rx_cnt_q <= BIT_CNT; // RULE1
              rx_bit_q <= '0;
              rx_st_q <= UART_DATA;
            end
            else
              rx_st_q <= UART_IDLE;
          UART_DATA:
          begin
            rx_shift_q <= {rx_line, rx_shift_q[7:1]};
            rx_cnt_q <= BIT_CNT;
            rx_bit_q <= rx_bit_q + 1'b1;
            if (rx_bit_q == BIT_LAST)
              rx_st_q <= ctrl_q[CTRL_PARITY_EN] ? UART_PARITY : UART_STOP; // RULE1
          end
          UART_PARITY:
          begin
            rx_par_q <= rx_line;
            rx_cnt_q <= BIT_CNT;
            rx_st_q <= UART_STOP;
          end
          UART_STOP:
          begin
            rx_st_q <= UART_IDLE;
            if (!rx_line || (ctrl_q[CTRL_PARITY_EN]
                && rx_par_q != arpc_parity(rx_shift_q, ctrl_q[CTRL_PARITY_ODD]))) // RULE1
              rx_err_q <= 1'b1;
            else
              rx_valid_q <= 1'b1;
          end
          default:
            rx_st_q <= UART_IDLE;
        endcase
      end
    end
  end

  // Packet framing; a bad character restarts at byte 0
  assign last_byte = (idx_q == POS_SUM && len_q == LEN_NONE)
                     || (idx_q > POS_SUM && idx_q == POS_SUM + {1'b0, len_q}); // RULE5 RULE7
  assign sum_next = (idx_q == POS_SUM) ? sum_q : arpc_add(sum_q, rx_shift_q); // RULE6

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      idx_q <= '0;
      src_q <= '0;
      dst_q <= '0;
      cmd_q <= '0;
      len_q <= '0;
      csum_q <= '0;
      sum_q <= '0;
      pkt_done_q <= 1'b0;
    end
    else
    begin
      pkt_done_q <= 1'b0;
      if (rx_err_q)
      begin
        idx_q <= '0;
        sum_q <= '0;
      end
      else if (rx_valid_q)
      begin
        case (idx_q)
          POS_SRC: src_q <= rx_shift_q; // RULE4
          POS_DST: dst_q <= rx_shift_q; // RULE4
          POS_CMD: cmd_q <= rx_shift_q; // RULE4
          POS_LEN: len_q <= rx_shift_q; // RULE5
          POS_SUM: csum_q <= rx_shift_q; // RULE6
          default: ;
        endcase
        if (last_byte)
        begin
          idx_q <= '0;
          sum_q <= sum_next;
          pkt_done_q <= 1'b1;
        end
        else
        begin
          idx_q <= idx_q + 1'b1;
          sum_q <= (idx_q == POS_SRC) ? rx_shift_q : sum_next;
        end
      end
    end
  end

  // Command decode and acceptance
  assign addr_ok = dst_q >= ADDR_LOW && dst_q <= ADDR_HIGH; // RULE3
  assign sum_ok = sum_q == csum_q; // RULE21
  assign cmd_ok = cmd_q <= CMD_TEMP && len_q == LEN_NONE; // RULE23
  // A command arriving while a reply is still going out is dropped
  assign accept = pkt_done_q && addr_ok && sum_ok && cmd_ok && !tx_busy;

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      amp_en_q <= AMP_EN_RESET;
    else if (accept && cmd_q == CMD_ENABLE)
      amp_en_q <= 1'b1; // RULE9
    else if (accept && cmd_q == CMD_DISABLE)
      amp_en_q <= 1'b0; // RULE10
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      cnt_ok_q <= '0;
      cnt_drop_q <= '0;
    end
    else if (pkt_done_q && addr_ok)
    begin
      if (accept)
        cnt_ok_q <= cnt_ok_q + 1'b1;
      else if (!sum_ok)
        cnt_drop_q <= cnt_drop_q + 1'b1; // RULE21
    end
  end

  // Reply image; status reflects the enable state the command leaves behind
  assign en_next = (cmd_q == CMD_ENABLE) | (amp_en_q & (cmd_q != CMD_DISABLE)); // RULE9 RULE10
  assign base_status = {en_next & ~supply_shutdown_q & ~alarms.overpower_alarm
                        & ~alarms.reflected_power_alarm,
                        alarms.fan_on, alarms.overpower_alarm, alarms.fan_fail,
                        alarms.partial_supply_fail, alarms.over_temp, alarms.high_temp,
                        alarms.reflected_power_alarm}; // RULE20
  assign ext_status = {unit_missing, function_fail, supply_shutdown_q, alarms.loop_fault,
                       4'h0}; // RULE11 RULE15 RULE18

  always_comb
  begin
    resp_d[0] = dst_q; // RULE22
    resp_d[1] = src_q; // RULE22
    resp_d[2] = cmd_q; // RULE19
    resp_d[5] = base_status; // RULE8
    resp_d[6] = ext_status;
    resp_total_d = RESP_HDR + 3'(LEN_BASE);
    case (cmd_q)
      CMD_EXT:
      begin
        resp_d[3] = LEN_EXT; // RULE11
        resp_total_d = RESP_HDR + 3'(LEN_EXT);
      end
      CMD_TEMP:
      begin
        resp_d[3] = LEN_TEMP;
        resp_d[5] = heat_sink_temp; // RULE12
      end
      default:
        resp_d[3] = LEN_BASE; // RULE20
    endcase
    resp_d[4] = arpc_add(arpc_add(arpc_add(resp_d[0], resp_d[1]), arpc_add(resp_d[2],
                resp_d[3])), arpc_add(resp_d[5], (resp_d[3] == LEN_EXT) ? resp_d[6]
                : 8'h00)); // RULE6 RULE21
  end

  // UART transmitter walking the reply image
  assign tx_busy = tx_st_q != UART_IDLE || tx_idx_q != tx_total_q;

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      for (int i = 0; i < RESP_MAX; i++)
        resp_q[i] <= '0;
      tx_total_q <= '0;
      tx_idx_q <= '0;
      tx_st_q <= UART_IDLE;
      tx_cnt_q <= '0;
      tx_bit_q <= '0;
      tx_shift_q <= '0;
      tx_line_q <= 1'b1;
    end
    else if (accept)
    begin
      for (int i = 0; i < RESP_MAX; i++)
        resp_q[i] <= resp_d[i];
      tx_total_q <= resp_total_d;
      tx_idx_q <= '0;
    end
    else if (tx_st_q != UART_IDLE && tx_cnt_q != '0)
      tx_cnt_q <= tx_cnt_q - 1'b1;
    else
    begin
      case (tx_st_q)
        UART_IDLE:
          if (tx_idx_q != tx_total_q)
          begin
            tx_shift_q <= resp_q[tx_idx_q];
            tx_line_q <= 1'b0; // RULE1
            tx_cnt_q <= BIT_CNT;
            tx_st_q <= UART_START;
          end
        UART_START:
        begin
          tx_line_q <= tx_shift_q[0];
          tx_cnt_q <= BIT_CNT;
          tx_bit_q <= '0;
          tx_st_q <= UART_DATA;
        end
        UART_DATA:
        begin
          tx_cnt_q <= BIT_CNT;
          tx_bit_q <= tx_bit_q + 1'b1;
          if (tx_bit_q == BIT_LAST)
          begin
            tx_line_q <= ctrl_q[CTRL_PARITY_EN]
                         ? arpc_parity(resp_q[tx_idx_q], ctrl_q[CTRL_PARITY_ODD]) : 1'b1;
            tx_st_q <= ctrl_q[CTRL_PARITY_EN] ? UART_PARITY : UART_STOP; // RULE1
          end
          else
          begin
            tx_shift_q <= {1'b0, tx_shift_q[7:1]};
            tx_line_q <= tx_shift_q[1];
          end
        end
        UART_PARITY:
        begin
          tx_line_q <= 1'b1;
          tx_cnt_q <= BIT_CNT;
          tx_st_q <= UART_STOP;
        end
        UART_STOP:
        begin
          tx_idx_q <= tx_idx_q + 1'b1;
          tx_st_q <= UART_IDLE;
        end
        default:
          tx_st_q <= UART_IDLE;
      endcase
    end
  end

  // Avalon-MM slave: one wait state on every access
  assign avs_waitrequest = (avs_read | avs_write) & ~ack_q;

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      ack_q <= 1'b0;
    else
      ack_q <= (avs_read | avs_write) & ~ack_q;
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      ctrl_q <= CTRL_RESET; // RULE1
    else if (avs_write && ack_q && avs_address == REG_CTRL && avs_byteenable[0])
      ctrl_q <= avs_writedata[1:0];
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      avs_readdata <= '0;
    else if (avs_read && !ack_q)
    begin
      case (avs_address)
        REG_CTRL: avs_readdata <= {30'h0, ctrl_q};
        REG_STATUS: avs_readdata <= {21'h0, tx_busy, sel2, sel1, 1'b0, alarms.reflected_power_alarm,
                                     alarms.overpower_alarm, loop_fail_alarm, function_fail,
                                     unit_missing, supply_shutdown_q, amp_drive_q};
        REG_COUNT: avs_readdata <= {16'h0, cnt_drop_q, cnt_ok_q};
        default: avs_readdata <= '0;
      endcase
    end
  end

  property p_bus_exclusive;
    @(posedge clk) disable iff (reset)
    !(tx_enable_bus1 && tx_enable_bus2);
  endproperty
  a_bus_exclusive: assert property (p_bus_exclusive) else $error("both pairs driven"); // RULE2

  property p_bus1_path;
    @(posedge clk) disable iff (reset)
    (sel1 && tx_busy) |=> (tx_enable_bus1 && !tx_enable_bus2 && tx_bus1 == $past(tx_line_q));
  endproperty
  a_bus1_path: assert property (p_bus1_path) else $error("bus 1 not driving"); // RULE2

  property p_foreign_addr;
    @(posedge clk) disable iff (reset)
    (pkt_done_q && !addr_ok && !tx_busy) |=> !tx_busy;
  endproperty
  a_foreign_addr: assert property (p_foreign_addr) else $error("foreign packet answered"); // RULE3

  property p_bad_sum;
    @(posedge clk) disable iff (reset)
    (pkt_done_q && (sum_q != csum_q) && !tx_busy) |=> !tx_busy [*2];
  endproperty
  a_bad_sum: assert property (p_bad_sum) else $error("bad checksum answered"); // RULE21

  property p_enable_cmd;
    @(posedge clk) disable iff (reset)
    (accept && cmd_q == CMD_ENABLE) |=> amp_en_q && resp_q[5][7] == $past(base_status[7]);
  endproperty
  a_enable_cmd: assert property (p_enable_cmd) else $error("enable not applied"); // RULE9

  property p_disable_cmd;
    @(posedge clk) disable iff (reset)
    (accept && cmd_q == CMD_DISABLE) |=> !amp_en_q ##1 !amp_enable;
  endproperty
  a_disable_cmd: assert property (p_disable_cmd) else $error("disable not applied"); // RULE10

  property p_echo;
    @(posedge clk) disable iff (reset)
    accept |=> resp_q[2] == $past(cmd_q) && resp_q[0] == $past(dst_q) && tx_total_q != '0;
  endproperty
  a_echo: assert property (p_echo) else $error("echo or source wrong"); // RULE19

  property p_base_len;
    @(posedge clk) disable iff (reset)
    (accept && cmd_q <= CMD_DISABLE) |=> resp_q[3] == LEN_BASE && tx_total_q == 3'h6;
  endproperty
  a_base_len: assert property (p_base_len) else $error("base status length wrong"); // RULE20

  property p_supply_shutdown;
    @(posedge clk) disable iff (reset)
    alarms.supply_fault |=> supply_shutdown_q ##1 !amp_enable;
  endproperty
  a_supply_shutdown: assert property (p_supply_shutdown) else $error("no shutdown"); // RULE15

  property p_overpower_recover;
    @(posedge clk) disable iff (reset)
    (amp_en_q && !supply_shutdown_q && !alarms.overpower_alarm
     && !alarms.reflected_power_alarm && !alarms.supply_fault && !accept) |=> amp_enable;
  endproperty
  a_overpower_recover: assert property (p_overpower_recover) else $error("no recovery"); // RULE16

  property p_bad_length;
    @(posedge clk) disable iff (reset)
    (pkt_done_q && len_q != LEN_NONE) |-> !accept;
  endproperty
  a_bad_length: assert property (p_bad_length) else $error("payload command accepted"); // RULE23
endmodule : arpc_top
`default_nettype wire

// >>> tb/arpc_host_model.sv
// Host controller model on the shared serial bus
`timescale 1ns/1ns
`default_nettype none
module arpc_host_model #(
  parameter int unsigned BIT_CYCLES = 16
)(
  input wire logic clk,
  input wire logic rx_line,
  output logic tx_line
);
  logic par_en = 1'b0;
  logic par_odd = 1'b0;
  initial tx_line = 1'b1;

  task automatic put_byte(input logic [7:0] b);
    logic [10:0] f;
    f = par_en ? {1'b1, (^b) ^ par_odd, b, 1'b0} : {2'b11, b, 1'b0};
    for (int i = 0; i < (par_en ? 11 : 10); i++)
    begin
      tx_line <= f[i];
      repeat (BIT_CYCLES) @(posedge clk);
    end
  endtask : put_byte

  // Late start detection still samples well inside each bit
  task automatic get_byte(output logic [7:0] b, output logic ok);
    int w;
    w = 0;
    b = 8'h00;
    while (rx_line !== 1'b0 && w < 40 * BIT_CYCLES)
    begin
      @(posedge clk);
      w++;
    end
    ok = (rx_line === 1'b0);
    if (ok)
    begin
      repeat (BIT_CYCLES / 2) @(posedge clk);
      for (int i = 0; i < 8; i++)
      begin
        repeat (BIT_CYCLES) @(posedge clk);
        b[i] = rx_line;
      end
      if (par_en)
      begin
        repeat (BIT_CYCLES) @(posedge clk);
        if (rx_line !== ((^b) ^ par_odd))
          ok = 1'b0;
      end
      // Stop bit must be high, else the character counts as lost
      repeat (BIT_CYCLES) @(posedge clk);
      if (rx_line !== 1'b1)
        ok = 1'b0;
    end
  endtask : get_byte
endmodule : arpc_host_model
`default_nettype wire

// >>> tb/arpc_top_bench.sv
// Self-checking bench for the remote packet control block
`timescale 1ns/1ns
`default_nettype none
module arpc_top_bench;
  import arpc_pkg::*;
  localparam int unsigned BC = 16;
  localparam logic [7:0] HOST = 8'h05;
  localparam logic [31:0] BADS [0:4] = '{32'h14000000, 32'h0f000000, 32'h10050000,
    32'h10000100, 32'h10020001};
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic sel_h = 1'b1;
  logic sel_l = 1'b0;
  logic host_tx, host_rx, tx1, tx2, en1, en2, amp_enable, loop_fail_alarm;
  arpc_alarm_s alarms = '0;
  logic [7:0] temp = 8'h3c;
  logic [7:0] rep [0:7];
  logic [31:0] rd;
  int nrep, err_total, n_compared, cycles;

  always #2 clk = ~clk;
  assign host_rx = sel_h ? tx1 : (sel_l ? tx2 : 1'b1);

  arpc_host_model #(.BIT_CYCLES(BC)) host (.clk(clk), .rx_line(host_rx), .tx_line(host_tx));
  arpc_top #(.BIT_CYCLES(BC)) uut (.clk(clk), .reset(reset), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(4'hf), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .bus_select_high(sel_h), .bus_select_low(sel_l), .rx_bus1(sel_h ? host_tx : 1'b1),
    .rx_bus2(sel_l ? host_tx : 1'b1), .tx_bus1(tx1), .tx_bus2(tx2), .tx_enable_bus1(en1),
    .tx_enable_bus2(en2), .alarms(alarms), .heat_sink_temp(temp), .amp_enable(amp_enable),
    .loop_fail_alarm(loop_fail_alarm));

  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp)
    begin
      err_total++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask : check

  task automatic tally_and_finish;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : tally_and_finish

  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 60000)
    begin
      err_total++;
      tally_and_finish();
    end
  end

  task automatic av_rd(input logic [3:0] a);
    @(posedge clk);
    avs_address <= a;
    avs_read <= 1'b1;
    @(posedge clk);
    while (avs_waitrequest !== 1'b0) @(posedge clk);
    rd = avs_readdata;
    avs_read <= 1'b0;
  endtask : av_rd

  task automatic av_wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= 1'b1;
    @(posedge clk);
    while (avs_waitrequest !== 1'b0) @(posedge clk);
    avs_write <= 1'b0;
  endtask : av_wr

  function automatic logic [7:0] base(input logic amp);
    base = {amp, alarms.fan_on, alarms.overpower_alarm, alarms.fan_fail,
      alarms.partial_supply_fail, alarms.over_temp, alarms.high_temp,
      alarms.reflected_power_alarm};
  endfunction : base

  task automatic run_cmd(input logic [7:0] dst, code, len, off);
    logic [7:0] pk [0:5];
    logic [7:0] b;
    logic ok;
    pk = '{HOST, dst, code, len, 8'h00, 8'h5a};
    pk[4] = HOST + dst + code + len + (len != 8'h00 ? 8'h5a : 8'h00) + off;
    @(posedge clk);
    for (int i = 0; i < 5 + len; i++)
      host.put_byte(pk[i]);
    nrep = 0;
    ok = 1'b1;
    while (ok && nrep < 8)
    begin
      host.get_byte(b, ok);
      if (ok && nrep == 0)
        check("pair enable", {sel_l, sel_h}, {en2, en1});
      if (ok)
        rep[nrep++] = b;
    end
  endtask : run_cmd

  task automatic chk_reply(input logic [7:0] dst, code, len, p0, p1);
    check("reply size", 5 + len, nrep);
    check("pair idle", 32'h0, {en2, en1});
    check("source", dst, rep[0]);
    check("destination", HOST, rep[1]);
    check("echo", code, rep[2]);
    check("count", len, rep[3]);
    check("checksum", 8'(dst + HOST + code + len + p0 + (len == 8'h02 ? p1 : 8'h00)),
      rep[4]);
    check("payload0", p0, rep[5]);
    if (len == 8'h02)
      check("payload1", p1, rep[6]);
  endtask : chk_reply

  initial
  begin
    alarms.function_ok = 1'b1;
    alarms.fan_on = 1'b1;
    alarms.high_temp = 1'b1;
    repeat (6) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    check("amp at reset", 32'h0, amp_enable);
    av_rd(REG_CTRL);
    check("ctrl reset", 32'h0, rd);
    av_rd(4'hc);
    check("unmapped", 32'h0, rd);
    run_cmd(8'h10, CMD_ENABLE, LEN_NONE, 8'h00);
    chk_reply(8'h10, CMD_ENABLE, LEN_BASE, base(1'b1), 8'h00);
    check("amp on", 32'h1, amp_enable);
    run_cmd(8'h13, CMD_BASE, LEN_NONE, 8'h00);
    chk_reply(8'h13, CMD_BASE, LEN_BASE, base(1'b1), 8'h00);
    for (int i = 0; i < 5; i++)
    begin
      run_cmd(BADS[i][31:24], BADS[i][23:16], BADS[i][15:8], BADS[i][7:0]);
      check("silent", 32'h0, nrep);
    end
    check("amp kept", 32'h1, amp_enable);
    run_cmd(8'h11, CMD_DISABLE, LEN_NONE, 8'h00);
    chk_reply(8'h11, CMD_DISABLE, LEN_BASE, base(1'b0), 8'h00);
    check("amp off", 32'h0, amp_enable);
    run_cmd(8'h12, CMD_TEMP, LEN_NONE, 8'h00);
    chk_reply(8'h12, CMD_TEMP, LEN_TEMP, temp, 8'h00);
    alarms.unit_present_input <= 1'b1;
    alarms.function_ok <= 1'b0;
    alarms.loop_fault <= 1'b1;
    run_cmd(8'h10, CMD_EXT, LEN_NONE, 8'h00);
    chk_reply(8'h10, CMD_EXT, LEN_EXT, base(1'b0), 8'hd0);
    check("loop fail", 32'h1, loop_fail_alarm);
    sel_h <= 1'b0;
    sel_l <= 1'b1;
    run_cmd(8'h10, CMD_ENABLE, LEN_NONE, 8'h00);
    chk_reply(8'h10, CMD_ENABLE, LEN_BASE, base(1'b1), 8'h00);
    // Both selects high picks no pair, so this disable must never arrive
    sel_h <= 1'b1;
    run_cmd(8'h10, CMD_DISABLE, LEN_NONE, 8'h00);
    check("no pair", 32'h0, nrep);
    sel_h <= 1'b0;
    for (int i = 0; i < 2; i++)
    begin
      alarms.overpower_alarm <= (i == 0);
      alarms.reflected_power_alarm <= (i == 1);
      repeat (4) @(posedge clk);
      check("amp alarmed", 32'h0, amp_enable);
      alarms.overpower_alarm <= 1'b0;
      alarms.reflected_power_alarm <= 1'b0;
      repeat (4) @(posedge clk);
      check("amp resumes", 32'h1, amp_enable);
    end
    alarms.supply_fault <= 1'b1;
    repeat (4) @(posedge clk);
    alarms.supply_fault <= 1'b0;
    repeat (4) @(posedge clk);
    check("amp shut", 32'h0, amp_enable);
    av_rd(REG_STATUS);
    check("shutdown flag", 32'h1, rd[1]);
    av_wr(REG_CTRL, 32'h4);
    repeat (4) @(posedge clk);
    check("amp restored", 32'h1, amp_enable);
    for (int i = 0; i < 2; i++)
    begin
      av_wr(REG_CTRL, i == 0 ? 32'h1 : 32'h3);
      host.par_en = 1'b1;
      host.par_odd = (i == 1);
      run_cmd(8'h13, CMD_BASE, LEN_NONE, 8'h00);
      chk_reply(8'h13, CMD_BASE, LEN_BASE, base(1'b1), 8'h00);
    end
    // Eight accepted commands, one own-address checksum failure
    av_rd(REG_COUNT);
    check("counts", 32'h00000108, rd);
    tally_and_finish();
  end
endmodule : arpc_top_bench
`default_nettype wire
